// ==== hw/lccr_consts.svh ====
`ifndef LCCR_CONSTS_SVH
`define LCCR_CONSTS_SVH

// Register bus geometry.
`define LCCR_ADDR_W        12
`define LCCR_DATA_W        8
`define LCCR_NUM_REGS      8
`define LCCR_IDX_W         3

// Register byte addresses, one per captured configuration octet.
`define LCCR_ADDR_LANES    12'h403
`define LCCR_ADDR_OCTETS   12'h404
`define LCCR_ADDR_FRAMES   12'h405
`define LCCR_ADDR_CONV     12'h406
`define LCCR_ADDR_CSN      12'h407
`define LCCR_ADDR_NP       12'h408
`define LCCR_ADDR_VERS     12'h409
`define LCCR_ADDR_HDCF     12'h40a

// Alignment-data octet position of the first captured octet (lane count).
`define LCCR_ILA_FIRST     4'h3
`define LCCR_ILA_LAST      4'ha
`define LCCR_LANE0         3'h0

// Masks that keep reserved bits at zero.
`define LCCR_MASK_LANES    8'h1f
`define LCCR_MASK_OCTETS   8'hff
`define LCCR_MASK_FRAMES   8'h1f
`define LCCR_MASK_CONV     8'hff
`define LCCR_MASK_CSN      8'hdf
`define LCCR_MASK_NP       8'hff
`define LCCR_MASK_VERS     8'hff
`define LCCR_MASK_HDCF     8'h9f

// Reset value of every captured register.
`define LCCR_RESET_VAL     8'h00

// Bank index of each captured register.
`define LCCR_IDX_LANES     3'h0
`define LCCR_IDX_OCTETS    3'h1
`define LCCR_IDX_FRAMES    3'h2
`define LCCR_IDX_CONV      3'h3
`define LCCR_IDX_CSN       3'h4
`define LCCR_IDX_NP        3'h5
`define LCCR_IDX_VERS      3'h6
`define LCCR_IDX_HDCF      3'h7

// Field positions inside a register.
`define LCCR_F_BYTE        7:0
`define LCCR_F_LOW5        4:0
`define LCCR_F_TOP3        7:5
`define LCCR_F_TOP2        7:6
`define LCCR_F_FLAG        7

`endif

// ==== hw/lccr_pkg.sv ====
`include "lccr_consts.svh"

package lccr_pkg;

  // Register index within the captured bank.
  typedef logic [`LCCR_IDX_W-1:0] lccr_idx_t;

  // Whole state of the register bank.
  typedef struct packed {
    logic [`LCCR_NUM_REGS-1:0][`LCCR_DATA_W-1:0] cfg;
    logic [`LCCR_DATA_W-1:0]                     rd_data;
  } lccr_state_s;

endpackage

// ==== hw/lccr_regs.sv ====
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// RULE_01: Fields load only from alignment octets seen on logical lane 0.
// RULE_02: Lane-count field holds lanes minus one, so four lanes reads 3.
// RULE_03: Octets-per-frame byte holds octets minus one; sender uses 1, 2 or 4.
// RULE_04: Frames-per-multiframe in bits 4..0; 01111 is 16, 11111 is 32.
// RULE_05: Converter-count byte holds converters minus one; sender uses 1, 2 or 4.
// RULE_06: Control bits per sample sit in bits 7..6; sender sends zero.
// RULE_07: Resolution sits in bits 4..0 beside control bits; bit 5 reserved.
// RULE_08: Subclass in bits 7..5, total bits per sample in bits 4..0.
// RULE_09: Link standard version in bits 7..5; value 1 means revision B.
// RULE_10: Samples per converter per frame in bits 4..0, count minus one.
// RULE_11: High-density flag in bit 7 beside control words per frame.
// RULE_12: Fields reset to zero, ignore writes, reserved bits read zero.
`include "lccr_consts.svh"

module lccr_regs
  import lccr_pkg::*;
(
  // Clock and reset.
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // Alignment data from the link layer, same clock.
  input  wire logic                     i_ila_valid,
  input  wire logic [2:0]               i_ila_lane,
  input  wire logic [3:0]               i_ila_index,
  input  wire logic [7:0]               i_ila_data,
  // Register port.
  input  wire logic [`LCCR_ADDR_W-1:0]  i_addr,
  input  wire logic [`LCCR_DATA_W-1:0]  i_wr_data,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [`LCCR_DATA_W-1:0]  o_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // Register map, one byte each, all read-only:
  //   0x403 lane count minus one in bits 4..0.
  //   0x404 octets per frame minus one, whole byte.
  //   0x405 frames per multiframe minus one in bits 4..0.
  //   0x406 converter count minus one, whole byte.
  //   0x407 control bits in 7..6, resolution in 4..0.
  //   0x408 subclass version in 7..5, total bits per sample in 4..0.
  //   0x409 link standard version in 7..5, samples per frame in 4..0.
  //   0x40a high-density flag in bit 7, control words in 4..0.
  // Any other address reads zero, and writes are dropped everywhere.

  // Maps a bus address to a bank index; the top bit is low when unmapped.
  // A plain chain costs a few comparators but reads like the map above.
  function automatic logic [`LCCR_IDX_W:0] addr_decode(input logic [`LCCR_ADDR_W-1:0] a);
    if (a == `LCCR_ADDR_LANES)
      addr_decode = {1'b1, `LCCR_IDX_LANES};
    else if (a == `LCCR_ADDR_OCTETS)
      addr_decode = {1'b1, `LCCR_IDX_OCTETS};
    else if (a == `LCCR_ADDR_FRAMES)
      addr_decode = {1'b1, `LCCR_IDX_FRAMES};
    else if (a == `LCCR_ADDR_CONV)
      addr_decode = {1'b1, `LCCR_IDX_CONV};
    else if (a == `LCCR_ADDR_CSN)
      addr_decode = {1'b1, `LCCR_IDX_CSN};
    else if (a == `LCCR_ADDR_NP)
      addr_decode = {1'b1, `LCCR_IDX_NP};
    else if (a == `LCCR_ADDR_VERS)
      addr_decode = {1'b1, `LCCR_IDX_VERS};
    else if (a == `LCCR_ADDR_HDCF)
      addr_decode = {1'b1, `LCCR_IDX_HDCF};
    else
      addr_decode = '0;
  endfunction

  // Per-register mask of live bits; reserved bits are forced to zero.
  // Masking at capture time means the read path never needs its own masks.
  function automatic logic [7:0] field_mask(input lccr_idx_t k);
    case (k)
      `LCCR_IDX_LANES:  field_mask = `LCCR_MASK_LANES;   // see RULE_02
      `LCCR_IDX_OCTETS: field_mask = `LCCR_MASK_OCTETS;  // see RULE_03
      `LCCR_IDX_FRAMES: field_mask = `LCCR_MASK_FRAMES;  // see RULE_04
      `LCCR_IDX_CONV:   field_mask = `LCCR_MASK_CONV;    // see RULE_05
      `LCCR_IDX_CSN:    field_mask = `LCCR_MASK_CSN;     // see RULE_06 see RULE_07
      `LCCR_IDX_NP:     field_mask = `LCCR_MASK_NP;      // see RULE_08
      `LCCR_IDX_VERS:   field_mask = `LCCR_MASK_VERS;    // see RULE_09 see RULE_10
      default:          field_mask = `LCCR_MASK_HDCF;    // see RULE_11
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  lccr_state_s q;
  lccr_state_s next_q;
  logic        capture;
  logic [3:0]  ila_off;

  // Only lane 0 alignment octets in the captured range are taken; the
  // other lanes repeat the same parameters and would only add hazards.
  // Values are stored raw: software must judge whether the link is legal,
  // since checking here would hide what the transmitter really sent.
  assign capture = i_ila_valid && (i_ila_lane == `LCCR_LANE0)          // see RULE_01
                   && (i_ila_index >= `LCCR_ILA_FIRST) && (i_ila_index <= `LCCR_ILA_LAST);
  assign ila_off = i_ila_index - `LCCR_ILA_FIRST;

  // Next-state logic: capture from the link, answer reads, never store writes.
  always_comb
  begin
    logic [`LCCR_IDX_W:0] dec;
    dec    = addr_decode(i_addr);
    next_q = q;
    for (int k = 0; k < `LCCR_NUM_REGS; k++)
    begin
      if (capture && (ila_off[`LCCR_IDX_W-1:0] == lccr_idx_t'(k)))
        next_q.cfg[k] = i_ila_data & field_mask(lccr_idx_t'(k));  // see RULE_12
    end
    // Read data stand only in the cycle after the strobe; zero otherwise.
    if (i_rd && dec[`LCCR_IDX_W])
      next_q.rd_data = q.cfg[dec[`LCCR_IDX_W-1:0]];
    else
      next_q.rd_data = `LCCR_RESET_VAL;
  end

  // Synchronous reset clears every captured field and the read data.
  // Fields hold until the next alignment pass, so a reset is the only clear.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      q <= '0;                                                       // see RULE_12
    else
      q <= next_q;
  end

  assign o_rd_data = q.rd_data;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Checks are quiet while reset is low; reset itself is checked further down
  // by one property that overrides the default disable.
  logic wr_seen;
  assign wr_seen = i_wr;

  // Named views of the captured fields; only the checks below read them.
  logic [4:0] lane_count;
  logic [7:0] octets_per_frame;
  logic [4:0] frames_per_multiframe;
  logic [7:0] converter_count;
  logic [1:0] control_bits;
  logic [4:0] resolution;
  logic [2:0] subclass_version;
  logic [4:0] total_bits_per_sample;
  logic [2:0] link_standard_version;
  logic [4:0] samples_per_frame;
  logic       high_density_flag;
  logic [4:0] control_words;

  // Field slices of the bank, one per field.
  assign lane_count            = q.cfg[`LCCR_IDX_LANES][`LCCR_F_LOW5];
  assign octets_per_frame      = q.cfg[`LCCR_IDX_OCTETS][`LCCR_F_BYTE];
  assign frames_per_multiframe = q.cfg[`LCCR_IDX_FRAMES][`LCCR_F_LOW5];
  assign converter_count       = q.cfg[`LCCR_IDX_CONV][`LCCR_F_BYTE];
  assign control_bits          = q.cfg[`LCCR_IDX_CSN][`LCCR_F_TOP2];
  assign resolution            = q.cfg[`LCCR_IDX_CSN][`LCCR_F_LOW5];
  assign subclass_version      = q.cfg[`LCCR_IDX_NP][`LCCR_F_TOP3];
  assign total_bits_per_sample = q.cfg[`LCCR_IDX_NP][`LCCR_F_LOW5];
  assign link_standard_version = q.cfg[`LCCR_IDX_VERS][`LCCR_F_TOP3];
  assign samples_per_frame     = q.cfg[`LCCR_IDX_VERS][`LCCR_F_LOW5];
  assign high_density_flag     = q.cfg[`LCCR_IDX_HDCF][`LCCR_F_FLAG];
  assign control_words         = q.cfg[`LCCR_IDX_HDCF][`LCCR_F_LOW5];

  // The octets-per-frame octet lands whole in its register.
  octets_capture_a: assert property (                                // see RULE_03
    capture && (i_ila_index == 4'h4) |=> q.cfg[1] == $past(i_ila_data))
    else $error("octets per frame not captured");

  // Octets on any other lane leave the whole bank alone.
  other_lane_a: assert property (                                    // see RULE_01
    i_ila_valid && (i_ila_lane != `LCCR_LANE0) |=> $stable(q.cfg))
    else $error("non-zero lane changed the bank");

  // Bits above the frame count stay clear.
  frames_resv_a: assert property (q.cfg[2][7:5] == 3'h0)             // see RULE_04
    else $error("frames reserved bits set");

  // The bit between control bits and resolution stays clear.
  csn_resv_a: assert property (q.cfg[4][5] == 1'b0)                  // see RULE_07
    else $error("control bits reserved bit set");

  // The density register keeps only its live bits.
  hdcf_resv_a: assert property (                                     // see RULE_11
    capture && (i_ila_index == 4'ha) |=> q.cfg[7] == ($past(i_ila_data) & 8'h9f))
    else $error("density register wrong");

  // A lone read answers exactly one cycle later.
  read_latency_a: assert property (                                  // see RULE_08
    i_rd && (i_addr == `LCCR_ADDR_NP) && !capture |=> o_rd_data == $past(q.cfg[5]))
    else $error("read data wrong or late");

  // Read data stand one cycle only.
  vers_read_a: assert property (                                     // see RULE_09
    i_rd && (i_addr == `LCCR_ADDR_VERS) ##1 !i_rd |=> o_rd_data == 8'h00)
    else $error("read data held too long");

  // Writes, whatever their data, change nothing.
  write_ignored_a: assert property (                                 // see RULE_12
    wr_seen && !capture |=> $stable(q.cfg))
    else $error("write changed a captured field");

  // The lane-count octet keeps only bits 4..0.
  lanes_capture_a: assert property (                                 // see RULE_02
    capture && (i_ila_index == 4'h3) |=> q.cfg[0] == ($past(i_ila_data) & 8'h1f))
    else $error("lane count not captured");

  // Addresses above the bank read zero.
  unmapped_a: assert property (                                      // see RULE_12
    i_rd && (i_addr > `LCCR_ADDR_HDCF) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");

  // Bits above the lane count stay clear.
  lanes_resv_a: assert property (q.cfg[`LCCR_IDX_LANES][`LCCR_F_TOP3] == 3'h0) // see RULE_12
    else $error("lane count reserved bits set");

  // The density register never shows its reserved bits.
  density_resv_a: assert property (                                  // see RULE_12
    (q.cfg[`LCCR_IDX_HDCF] & ~`LCCR_MASK_HDCF) == `LCCR_RESET_VAL)
    else $error("density reserved bits set");

  ////////////////////////////////////////////////////////////////////////////
  // Field checks, one per field.

  // Lane count follows its octet in bits 4..0.
  lanes_field_a: assert property (                                   // see RULE_02
    capture && (ila_off == `LCCR_IDX_LANES)
    |=> lane_count == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("lane count field wrong");

  // Octets per frame take the whole octet.
  octets_field_a: assert property (                                  // see RULE_03
    capture && (ila_off == `LCCR_IDX_OCTETS)
    |=> octets_per_frame == $past(i_ila_data[`LCCR_F_BYTE]))
    else $error("octets per frame field wrong");

  // Frames per multiframe follow the octet into bits 4..0.
  frames_field_a: assert property (                                  // see RULE_04
    capture && (ila_off == `LCCR_IDX_FRAMES)
    |=> frames_per_multiframe == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("frames per multiframe field wrong");

  // Converter count takes the whole octet.
  conv_field_a: assert property (                                    // see RULE_05
    capture && (ila_off == `LCCR_IDX_CONV)
    |=> converter_count == $past(i_ila_data[`LCCR_F_BYTE]))
    else $error("converter count field wrong");

  // Control bits per sample sit in bits 7..6.
  ctrl_bits_field_a: assert property (                               // see RULE_06
    capture && (ila_off == `LCCR_IDX_CSN)
    |=> control_bits == $past(i_ila_data[`LCCR_F_TOP2]))
    else $error("control bits field wrong");

  // Resolution sits in bits 4..0 of the same register.
  resolution_field_a: assert property (                              // see RULE_07
    capture && (ila_off == `LCCR_IDX_CSN)
    |=> resolution == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("resolution field wrong");

  // Subclass version sits in bits 7..5.
  subclass_field_a: assert property (                                // see RULE_08
    capture && (ila_off == `LCCR_IDX_NP)
    |=> subclass_version == $past(i_ila_data[`LCCR_F_TOP3]))
    else $error("subclass version field wrong");

  // Total bits per sample sit in bits 4..0.
  sample_width_a: assert property (                                  // see RULE_08
    capture && (ila_off == `LCCR_IDX_NP)
    |=> total_bits_per_sample == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("total bits per sample field wrong");

  // Link standard version sits in bits 7..5.
  version_field_a: assert property (                                 // see RULE_09
    capture && (ila_off == `LCCR_IDX_VERS)
    |=> link_standard_version == $past(i_ila_data[`LCCR_F_TOP3]))
    else $error("link standard version field wrong");

  // Samples per converter per frame sit in bits 4..0.
  samples_field_a: assert property (                                 // see RULE_10
    capture && (ila_off == `LCCR_IDX_VERS)
    |=> samples_per_frame == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("samples per frame field wrong");

  // The high-density flag sits in bit 7.
  density_flag_a: assert property (                                  // see RULE_11
    capture && (ila_off == `LCCR_IDX_HDCF)
    |=> high_density_flag == $past(i_ila_data[`LCCR_F_FLAG]))
    else $error("high density flag wrong");

  // Control words per frame sit in bits 4..0 beside the flag.
  ctrl_words_a: assert property (                                    // see RULE_11
    capture && (ila_off == `LCCR_IDX_HDCF)
    |=> control_words == $past(i_ila_data[`LCCR_F_LOW5]))
    else $error("control words field wrong");

  // Per register: a lone read returns it, and a capture elsewhere leaves it.
  for (genvar g = 0; g < `LCCR_NUM_REGS; g++)
  begin : g_reg
    read_each_a: assert property (                                   // see RULE_12
      i_rd && !capture && (i_addr == `LCCR_ADDR_LANES + 12'(g))
      |=> o_rd_data == $past(q.cfg[g]))
      else $error("register read returned a wrong value");

    capture_only_a: assert property (                                // see RULE_01
      capture && (ila_off != 4'(g)) |=> $stable(q.cfg[g]))
      else $error("capture touched another register");
  end

  // Without a read strobe the data lines fall back to zero next cycle.
  rd_idle_a: assert property (!i_rd |=> o_rd_data == `LCCR_RESET_VAL)  // see RULE_12
    else $error("read data stood without a strobe");

  // Addresses below the bank read zero as well.
  unmapped_low_a: assert property (                                  // see RULE_12
    i_rd && (i_addr < `LCCR_ADDR_LANES) |=> o_rd_data == `LCCR_RESET_VAL)
    else $error("low unmapped read not zero");

  // A read that meets a capture of the same register sees the old value.
  read_capture_a: assert property (                                  // see RULE_12
    capture && i_rd && (i_addr == `LCCR_ADDR_LANES + 12'(ila_off))
    |=> o_rd_data == $past(q.cfg[ila_off[`LCCR_IDX_W-1:0]]))
    else $error("read during capture returned the new value");

  // Nothing but a lane 0 capture moves the bank.
  bank_hold_a: assert property (!capture |=> $stable(q.cfg))         // see RULE_01
    else $error("bank changed without a capture");

  // Reset itself is checked, so this one is not disabled by it.
  reset_clear_a: assert property (@(posedge i_clk) disable iff (1'b0)  // see RULE_12
    !i_rst_n |=> (q.cfg == '0) && (o_rd_data == `LCCR_RESET_VAL))
    else $error("reset left a field set");

  // Main scenarios: capture then read, write then read, reads back to back, captures back to back.
  cap_lane0_c:   cover property (capture ##1 i_rd && (i_addr == `LCCR_ADDR_OCTETS));
  wr_then_rd_c:  cover property (i_wr ##1 i_rd);
  b2b_rd_c:      cover property (i_rd ##1 i_rd);
  b2b_cap_c:     cover property (capture ##1 capture);

endmodule // lccr_regs

// ==== verification/lccr_ila_tx.sv ====
`timescale 1ns/1ps
// Link transmitter model: sends the fourteen alignment octets once per start.
module lccr_ila_tx (
  // Clock and start request.
  input  wire logic        i_clk,
  input  wire logic        i_start,
  input  wire logic [2:0]  i_lane,
  input  wire logic [63:0] i_cfg,
  // Alignment octet stream.
  output logic             o_valid,
  output logic [2:0]       o_lane,
  output logic [3:0]       o_index,
  output logic [7:0]       o_data
);
  // The stream starts idle.
  initial
  begin
    o_valid = 1'b0;
    o_lane  = 3'h0;
    o_index = 4'h0;
    o_data  = 8'h00;
  end
  // Octets 3 to 10 carry the configuration as given, reserved bits included; no legality check.
  function automatic logic [7:0] octet(input logic [3:0] idx);
    return (idx >= 4'h3 && idx <= 4'ha) ? i_cfg[{idx - 4'h3, 3'h0} +: 8] : 8'ha5;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  // Idle data toggles so that a stale octet never passes for a fresh one.
  always @(posedge i_clk)
  begin
    if (o_valid && o_index != 4'hd)
    begin
      o_index <= o_index + 4'h1;
      o_data  <= octet(o_index + 4'h1);
    end
    else if (i_start)
    begin
      o_valid <= 1'b1;
      o_lane  <= i_lane;
      o_index <= 4'h0;
      o_data  <= octet(4'h0);
    end
    else
    begin
      o_valid <= 1'b0;
      o_data  <= ~o_data;
    end
  end
endmodule // lccr_ila_tx

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// Bench for the captured link configuration bank.
module tb_top;
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, start = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [7:0]  i_wr_data = 8'h00, o_rd_data, ila_data;
  logic [2:0]  lane = 3'h0, ila_lane;
  logic [3:0]  ila_index;
  logic [63:0] cfg = 64'h0;
  logic        ila_valid;
  int          failures = 0, samples_checked = 0;
  // Half period of 2.5 ns gives 200 MHz.
  always #2.5 i_clk = ~i_clk;
  lccr_ila_tx u_lccr_ila_tx (.i_clk(i_clk), .i_start(start), .i_lane(lane), .i_cfg(cfg),
    .o_valid(ila_valid), .o_lane(ila_lane), .o_index(ila_index), .o_data(ila_data));
  lccr_regs u_lccr_regs (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ila_valid(ila_valid),
    .i_ila_lane(ila_lane), .i_ila_index(ila_index), .i_ila_data(ila_data), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data));
  //////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Synchronous reset held for twelve edges.
  task automatic do_reset();
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
  endtask
  // Read strobe for one cycle; data is compared in the following cycle only.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    samples_checked++;
    if (o_rd_data !== e)
    begin
      failures++;
      $display("unexpected rd_data at %h: expected %h, seen %h", a, e, o_rd_data);
    end
  endtask
  // A write is accepted on the bus but must change nothing.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr      <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  // Reads the eight captured octets and one unmapped address.
  task automatic chk_all(input logic [63:0] e);
    for (int i = 0; i < 8; i++)
      rd(12'h403 + 12'(i), e[i*8 +: 8]);
    rd(12'h40b, 8'h00);
  endtask
  // Sends one alignment sequence and waits, bounded, for the stream to end.
  task automatic send(input logic [2:0] l, input logic [63:0] c);
    int n;
    n = 0;
    @(posedge i_clk);
    start <= 1'b1;
    lane  <= l;
    cfg   <= c;
    @(posedge i_clk);
    start <= 1'b0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while ((ila_valid || n < 2) && n < 40);
    if (n >= 40)
    begin
      failures++;
      conclude();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, ignored writes, lane filtering, masks, second reset.
  initial
  begin
    do_reset();
    chk_all(64'h0);
    wr(12'h404, 8'hff);
    rd(12'h404, 8'h00);
    send(3'h1, 64'hff21302f03ef0303);
    chk_all(64'h0);
    send(3'h0, 64'hff21302f03ef0303);
    chk_all(64'h9f21300f030f0303);
    wr(12'h406, 8'h55);
    rd(12'h406, 8'h03);
    send(3'h1, 64'h00201010001f0101);
    chk_all(64'h9f21300f030f0303);
    send(3'h0, 64'h00201010001f0101);
    chk_all(64'h00201010001f0101);
    do_reset();
    chk_all(64'h0);
    conclude();
  end
endmodule // tb_top
